// ### rtl/strobe_dll_pkg.sv
// How it works
// RULE1 - Offer 0, 45, 90, 135 degree strobe shifts.
// RULE2 - Shifts are multiples of 45 degrees, common reference.
// RULE3 - Zero shift bypasses loop and strobe block; the code skips only the chain, and the postamble gate still applies.
// RULE4 - Comparator steps Gray counter toward phase lock.
// RULE5 - Wait 2560 or 512 cycles after reset.
// RULE6 - Reference at least 300 MHz, multiplied when slow.
// RULE7 - Doubled or quadrupled reference limits available shift.
// RULE8 - Shifted strobe drives bus and core route.
// RULE9 - Delay setting goes to strobe blocks and core.
// RULE10 - Each sub-bank uses exactly one clock tree.
// RULE11 - Each strobe pin has its own strobe block.
// RULE12 - Setting registers load only on update enable.
// RULE13 - Update enable from reference or user clock.
// RULE14 - Strobe chain has four loop-identical elements.
// RULE15 - First element uses setting or setting plus offset.
// RULE16 - Setting from either end loop or core.
// RULE17 - Core Gray setting applies to one to four elements.
// RULE18 - Postamble gate forces shifted strobe low.
// RULE19 - Delay settings carried in Gray code.
// RULE20 - Gating covers the postamble low interval.
// RULE21 - Gate opens half cycle late, closes at once.
// RULE22 - Counter resets mid-range; update every eight cycles.
// RULE23 - Lock asserts after wait, clears on reset.
package strobe_dll_pkg;

   // ----------------------------------------------------------------
   // Widths and constants
   // ----------------------------------------------------------------
   localparam int SET_W = 7;                      // Delay setting width.
   localparam int NUM_PINS = 4;                   // Strobe pins served by one loop.
   localparam int CHAIN_LEN = 4;                  // Elements per strobe chain.
   localparam logic [SET_W-1:0] MID_SETTING = 7'h40;  // Binary mid-range reset value.
   localparam logic [3:0] UPDATE_PERIOD = 4'h8;   // Reference cycles per update.
   localparam logic [11:0] LOCK_WAIT_LOW_JITTER = 12'hA00;  // 2560 cycles.
   localparam logic [11:0] LOCK_WAIT_NORMAL = 12'h200;      // 512 cycles.

   // Shift codes, in units of 45 degrees.
   localparam logic [1:0] SHIFT_0 = 2'h0;
   localparam logic [1:0] SHIFT_135 = 2'h3;

   // Reference multiplier modes.
   typedef enum logic [1:0] {
      REF_X1 = 2'h0,
      REF_X2 = 2'h1,
      REF_X4 = 2'h2
   } ref_mode_t;

   // Setting source selection.
   typedef enum logic [1:0] {
      SRC_LOOP_A = 2'h0,
      SRC_LOOP_B = 2'h1,
      SRC_CORE = 2'h2
   } set_src_t;

   // Binary to Gray conversion.
   function automatic logic [SET_W-1:0] to_gray(input logic [SET_W-1:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   // Gray to binary conversion.
   function automatic logic [SET_W-1:0] from_gray(input logic [SET_W-1:0] g);
      logic [SET_W-1:0] b;
      b = '0;
      b[SET_W-1] = g[SET_W-1];
      for (int i = SET_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      from_gray = b;
   endfunction

endpackage

// ### rtl/strobe_logic_block.sv
`timescale 1ns/1ps
`default_nettype none
// One strobe pin's logic: held settings, delay chain, postamble gate.
module strobe_logic_block (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic update_en,
   input wire logic [strobe_dll_pkg::SET_W-1:0] setting_in,
   input wire logic [strobe_dll_pkg::SET_W-1:0] offset_in,
   input wire logic use_offset,
   input wire logic [2:0] chain_count,
   input wire logic [1:0] shift_sel,
   input wire logic strobe_in,
   input wire logic gate_req,
   output logic strobe_bus,
   output logic [strobe_dll_pkg::SET_W-1:0] first_elem_setting
);
   import strobe_dll_pkg::*;

   // ----------------------------------------------------------------
   // Held settings
   // ----------------------------------------------------------------
   logic [SET_W-1:0] held_setting;  // Gray setting seen by the chain.
   logic [SET_W-1:0] held_offset;   // Gray phase offset.
   logic [CHAIN_LEN:0] taps;        // Model of the chain as a strobe shift line.
   logic gate_half;                 // Gate captured on the falling edge.
   logic [SET_W-1:0] sum_bin;       // Setting plus offset, binary.
   logic [1:0] eff_shift;           // Shift after chain count limit.
   logic shifted;                   // Strobe after chosen tap.

   // Load only on update so that all elements move together.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_setting <= '0;
         held_offset <= '0;
      end else if (update_en) begin  // RULE12
         held_setting <= setting_in;
         held_offset <= offset_in;
      end
   end

   // First element takes the setting, or the setting plus offset.
   // The sum wraps on purpose; the carry out of the setting width is dropped.
   assign sum_bin = SET_W'(from_gray(held_setting) + from_gray(held_offset));
   assign first_elem_setting = use_offset ? to_gray(sum_bin) : held_setting;  // RULE15

   // ----------------------------------------------------------------
   // Delay chain
   // ----------------------------------------------------------------
   // Four identical stages; each stands for one element of the chain.
   assign taps[0] = strobe_in;
   genvar k;
   generate
      for (k = 0; k < CHAIN_LEN; k++) begin : g_elem
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               taps[k+1] <= 1'b0;
            end else begin
               taps[k+1] <= taps[k];  // RULE14
            end
         end
      end
   endgenerate

   // The tap used never exceeds the number of enabled elements.
   assign eff_shift = ({1'b0, shift_sel} > chain_count) ? chain_count[1:0] : shift_sel;  // RULE17
   // Zero shift takes the raw pin and bypasses the chain.
   assign shifted = (eff_shift == SHIFT_0) ? strobe_in : taps[eff_shift];  // RULE3

   // ----------------------------------------------------------------
   // Postamble gate
   // ----------------------------------------------------------------
   // Opening is retimed on the falling edge; closing is not retimed.
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_half <= 1'b0;
      end else begin
         gate_half <= gate_req;  // RULE21
      end
   end

   // AND of request and retimed request grounds the strobe in postamble.
   assign strobe_bus = shifted & gate_half & gate_req;  // RULE18 RULE20

   gate_close_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gate_req |-> !strobe_bus) else $error("Strobe passed while gate closed.");  // RULE18
endmodule
`default_nettype wire

// ### rtl/strobe_dll_delay_control.sv
`timescale 1ns/1ps
`default_nettype none
// Loop, update enable, lock timer, APB registers and strobe blocks.
module strobe_dll_delay_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic loop_reset_pin,
   input wire logic user_clk_tick,
   input wire logic phase_up,
   input wire logic [strobe_dll_pkg::SET_W-1:0] far_setting,
   input wire logic [strobe_dll_pkg::SET_W-1:0] core_setting,
   input wire logic [strobe_dll_pkg::NUM_PINS-1:0] strobe_pin,
   input wire logic [strobe_dll_pkg::NUM_PINS-1:0] gate_req,
   output logic [strobe_dll_pkg::NUM_PINS-1:0] strobe_bus,
   output logic [strobe_dll_pkg::NUM_PINS-1:0] strobe_core,
   output logic [strobe_dll_pkg::SET_W-1:0] delay_setting,
   output logic update_en,
   output logic locked
);
   import strobe_dll_pkg::*;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_ADDR = 12'h000;   // Control bits.
   localparam logic [11:0] SHIFT_ADDR = 12'h004;  // Per-pin shift codes.
   localparam logic [11:0] OFFS_ADDR = 12'h008;   // Phase offset.
   localparam logic [11:0] STAT_ADDR = 12'h00C;   // Status.

   logic soft_reset;        // Loop reset from software.
   logic low_jitter;        // Selects the long lock wait.
   logic user_update;       // Update enable follows user clock tick.
   logic use_offset;        // First element adds offset.
   ref_mode_t ref_mode;     // Reference multiplier.
   set_src_t set_src;       // Setting source for strobe chains.
   logic [2:0] chain_count; // Elements that take the setting, 1 to 4.
   logic [7:0] shift_sel;   // Two bits per pin.
   logic [SET_W-1:0] phase_offset;  // Gray phase offset.

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   wire wr_strobe = psel & penable & pwrite;
   wire rd_strobe = psel & penable & ~pwrite;
   wire addr_hit = (paddr == CTRL_ADDR) | (paddr == SHIFT_ADDR) |
                   (paddr == OFFS_ADDR) | (paddr == STAT_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;

   // Control register writes; unmapped writes are dropped.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_reset <= 1'b0;
         low_jitter <= 1'b0;
         user_update <= 1'b0;
         use_offset <= 1'b0;
         ref_mode <= REF_X1;
         set_src <= SRC_LOOP_A;
         chain_count <= 3'h4;
      end else if (wr_strobe && paddr == CTRL_ADDR) begin
         soft_reset <= pwdata[0];
         low_jitter <= pwdata[1];
         user_update <= pwdata[2];  // RULE13
         use_offset <= pwdata[3];
         ref_mode <= ref_mode_t'(pwdata[5:4]);
         set_src <= set_src_t'(pwdata[7:6]);
         // Zero elements is not legal; it is held at one.
         chain_count <= (pwdata[10:8] == 3'h0) ? 3'h1 :
                        (pwdata[10:8] > 3'h4) ? 3'h4 : pwdata[10:8];  // RULE17
      end
   end

   // Shift limit per reference mode: doubled ref keeps 45 degrees
   // (the largest step under 67.5), quadrupled keeps zero (below 45).
   wire [1:0] shift_cap = (ref_mode == REF_X2) ? 2'h1 :
                          (ref_mode == REF_X4) ? 2'h0 : SHIFT_135;  // RULE7
   function automatic logic [1:0] clip(input logic [1:0] s, input logic [1:0] cap);
      clip = (s > cap) ? cap : s;
   endfunction

   // Shift and offset registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_sel <= '0;
         phase_offset <= '0;
      end else begin
         if (wr_strobe && paddr == SHIFT_ADDR) begin
            shift_sel <= pwdata[7:0];  // RULE1 RULE2
         end
         if (wr_strobe && paddr == OFFS_ADDR) begin
            phase_offset <= pwdata[SET_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Loop counter
   // ----------------------------------------------------------------
   wire loop_reset = soft_reset | loop_reset_pin;  // RULE5
   logic [SET_W-1:0] count_bin;  // Binary count behind the Gray output.
   wire [SET_W-1:0] next_count = phase_up ?
      ((count_bin == {SET_W{1'b1}}) ? count_bin : count_bin + 7'h01) :
      ((count_bin == '0) ? count_bin : count_bin - 7'h01);

   // Comparator direction steps the count every reference cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_bin <= MID_SETTING;
      end else if (loop_reset) begin
         count_bin <= MID_SETTING;  // RULE22
      end else begin
         count_bin <= next_count;  // RULE4
      end
   end

   // Gray output changes one bit per step.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_setting <= to_gray(MID_SETTING);
      end else begin
         delay_setting <= to_gray(loop_reset ? MID_SETTING : next_count);  // RULE19 RULE9
      end
   end

   // ----------------------------------------------------------------
   // Update enable
   // ----------------------------------------------------------------
   logic [3:0] upd_cnt;  // Reference cycles since last update.
   wire ref_tick = (upd_cnt == UPDATE_PERIOD - 4'h1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_cnt <= '0;
      end else if (loop_reset || ref_tick) begin
         upd_cnt <= '0;
      end else begin
         upd_cnt <= upd_cnt + 4'h1;  // RULE22
      end
   end
   assign update_en = user_update ? user_clk_tick : ref_tick;  // RULE13

   // ----------------------------------------------------------------
   // Lock timer
   // ----------------------------------------------------------------
   logic [11:0] lock_cnt;  // Cycles since loop reset.
   wire [11:0] lock_target = low_jitter ? LOCK_WAIT_LOW_JITTER : LOCK_WAIT_NORMAL;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt <= '0;
         locked <= 1'b0;
      end else if (loop_reset) begin
         lock_cnt <= '0;
         locked <= 1'b0;  // RULE23
      end else if (lock_cnt < lock_target) begin
         lock_cnt <= lock_cnt + 12'h001;
      end else begin
         locked <= 1'b1;  // RULE23 RULE5
      end
   end

   // ----------------------------------------------------------------
   // Setting source and strobe blocks
   // ----------------------------------------------------------------
   // Source of the chain setting: this loop, the far-end loop, or core.
   wire [SET_W-1:0] chain_setting = (set_src == SRC_LOOP_B) ? far_setting :
                                    (set_src == SRC_CORE) ? core_setting :
                                    delay_setting;  // RULE16

   // All pins of this sub-bank share one clock tree: pclk stands in
   // for the memory_phy_clock_tree here.
   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++) begin : g_pin
         strobe_logic_block u_blk (  // RULE11 RULE10
            .pclk(pclk),
            .presetn(presetn),
            .update_en(update_en),
            .setting_in(chain_setting),
            .offset_in(phase_offset),
            .use_offset(use_offset),
            .chain_count(chain_count),
            .shift_sel(clip(shift_sel[2*p+1:2*p], shift_cap)),
            .strobe_in(strobe_pin[p]),
            .gate_req(gate_req[p]),
            .strobe_bus(strobe_bus[p]),
            .first_elem_setting()
         );
      end
   endgenerate
   assign strobe_core = strobe_bus;  // RULE8

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   wire [31:0] ctrl_word = {21'h0, chain_count, set_src, ref_mode, use_offset,
                            user_update, low_jitter, soft_reset};
   wire [31:0] stat_word = {8'h0, lock_cnt, 4'h0, locked, delay_setting};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= (paddr == CTRL_ADDR) ? ctrl_word :
                   (paddr == SHIFT_ADDR) ? {24'h0, shift_sel} :
                   (paddr == OFFS_ADDR) ? {25'h0, phase_offset} :
                   (paddr == STAT_ADDR) ? stat_word : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence reset_seen;
      loop_reset;
   endsequence
   lock_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      reset_seen |=> !locked) else $error("Lock survived loop reset.");  // RULE23
   lock_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(locked) |-> lock_cnt == lock_target) else $error("Lock early.");  // RULE23
   gray_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      !loop_reset |=> $countones(delay_setting ^ $past(delay_setting)) <= 1)
      else $error("Setting moved more than one bit.");  // RULE19
   mid_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      loop_reset |=> count_bin == MID_SETTING) else $error("No mid reset.");  // RULE22
   update_period_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ref_tick && !loop_reset) |=> !ref_tick [*7]) else $error("Update too often.");  // RULE22
   step_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      (phase_up && !loop_reset && count_bin < 7'h7F) |=> count_bin == $past(count_bin) + 7'h01)
      else $error("Counter did not step up.");  // RULE4
   pready_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pready) else $error("Bus not answered.");
   core_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      strobe_core == strobe_bus) else $error("Core strobe differs.");  // RULE8
endmodule
`default_nettype wire

// ### tb/strobe_source.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Memory-side strobe source
// --------------------------------------------------------------
// A driven pin follows level; low is the pre- or postamble.
// A released pin has no pull, so it toggles every cycle.
// That way a gate that leaks shows up instead of hiding as X.
module strobe_source (
   input wire logic pclk,
   input wire logic [3:0] drive,
   input wire logic [3:0] level,
   output logic [3:0] strobe
);
   initial strobe = 4'h0;
   // Each pin is either driven or glitching, never both.
   always @(posedge pclk) begin
      strobe <= (drive & level) | (~drive & ~strobe);
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
   import strobe_dll_pkg::*;
   // --------------------------------------------------------------
   // Stimulus and observed signals
   // --------------------------------------------------------------
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   // The loop pin reset is held from the start, so the setting stays at mid-range
   // through the first register reads; the pin-reset step below releases it.
   logic pready, pslverr, err, loop_reset_pin = 1, user_clk_tick = 0, phase_up = 0;
   logic [SET_W-1:0] far_setting = 7'h00, core_setting = 7'h00, delay_setting, last_set, b0;
   logic [3:0] strobe_pin, gate_req = 4'h0, strobe_bus, strobe_core, drive = 4'hF;
   logic [3:0] level = 4'h0, gprev;
   logic update_en, locked;
   int mismatches = 0, samples_checked = 0, seed = 32'h7FD3, n, upd_cnt = 0;
   int sh[8] = '{0, 1, 2, 3, 3, 3, 3, 3};
   int md[8] = '{0, 0, 0, 0, 1, 2, 0, 0};
   int ct[8] = '{4, 4, 4, 4, 4, 4, 1, 2};

   // The bench clock also stands in for the loop reference, at 10 MHz, far below the 300 MHz minimum.
   initial forever #50 pclk = ~pclk;

   strobe_dll_delay_control strobe_dll_delay_control_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_reset_pin(loop_reset_pin),
      .user_clk_tick(user_clk_tick), .phase_up(phase_up), .far_setting(far_setting),
      .core_setting(core_setting), .strobe_pin(strobe_pin), .gate_req(gate_req),
      .strobe_bus(strobe_bus), .strobe_core(strobe_core), .delay_setting(delay_setting),
      .update_en(update_en), .locked(locked));
   strobe_source strobe_source_i (.pclk(pclk), .drive(drive), .level(level),
      .strobe(strobe_pin));

   // --------------------------------------------------------------
   // Expectation helpers
   // --------------------------------------------------------------
   // Own Gray decode, kept apart from the design's helper on purpose.
   function automatic logic [SET_W-1:0] g2b(input logic [SET_W-1:0] g);
      logic [SET_W-1:0] b;
      b = g;
      for (int i = SET_W - 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
      return b;
   endfunction
   // Slow references cap the shift; so does a short element chain.
   function automatic int exp_delay(input int s, input int m, input int c);
      int cap;
      cap = (m == 0) ? 3 : ((m == 1) ? 1 : 0);
      if (cap > c) cap = c;
      return (s < cap) ? s : cap;
   endfunction

   // --------------------------------------------------------------
   // Bus, wait and closing tasks
   // --------------------------------------------------------------
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Edges until lock, bounded well past the longest wait.
   task automatic lock_time(output int c);
      c = 0;
      do begin @(posedge pclk); #1; c++; end while (locked !== 1'b1 && c < 3000);
   endtask
   task automatic wait_upd(output int c);
      c = 0;
      do begin @(posedge pclk); #1; c++; end while (update_en !== 1'b1 && c < 50);
   endtask
   // Step pin p from a settled low and count edges until it emerges.
   task automatic measure(input int p, output int d);
      @(posedge pclk);
      drive <= 4'hF;
      level <= 4'h0;
      gate_req <= 4'hF;
      repeat (8) @(posedge pclk);
      level <= 4'hF;
      d = 0;
      do begin @(posedge pclk); #1; d++; end while (strobe_pin[p] !== 1'b1 && d < 10);
      d = 0;
      while (strobe_bus[p] !== 1'b1 && d < 10) begin @(posedge pclk); #1; d++; end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Every setting change, except one onto mid-range 7'h60, flips a single bit.
   always @(posedge pclk) begin
      if (update_en === 1'b1) upd_cnt++;
      #1;
      if (presetn && delay_setting !== last_set && delay_setting !== 7'h60) begin
         `CHK("gray_step", 1, $countones(delay_setting ^ last_set))
      end
      last_set = delay_setting;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      end_sim;
   end

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      `CHK("reset_setting", 7'h60, delay_setting)
      `CHK("reset_locked", 1'b0, locked)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl_reset", 32'h400, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("stat_setting", 8'h60, rd[7:0])
      apb(1'b1, 12'h004, 32'hE4);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("shift_rb", 32'hE4, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      `CHK("unmapped_rd", 32'h0, rd)
      // Pin reset, then the soft bit with low jitter selected.
      @(posedge pclk);
      loop_reset_pin <= 1'b1;
      @(posedge pclk);
      loop_reset_pin <= 1'b0;
      #1;
      `CHK("pin_rst_lock", 1'b0, locked)
      `CHK("pin_rst_set", 7'h60, delay_setting)
      lock_time(n);
      `CHK("lock_512", 1'b1, n >= 505 && n <= 520)
      apb(1'b1, 12'h000, 32'h403);
      apb(1'b1, 12'h000, 32'h402);
      #1;
      `CHK("soft_rst_lock", 1'b0, locked)
      lock_time(n);
      `CHK("lock_2560", 1'b1, n >= 2550 && n <= 2570)
      // The comparator direction steers the counter both ways.
      @(posedge pclk);
      phase_up <= 1'b1;
      #1;
      b0 = g2b(delay_setting);
      repeat (40) @(posedge pclk);
      #1;
      `CHK("step_up", 1'b1, g2b(delay_setting) > b0)
      @(posedge pclk);
      phase_up <= 1'b0;
      #1;
      b0 = g2b(delay_setting);
      repeat (40) @(posedge pclk);
      #1;
      `CHK("step_down", 1'b1, g2b(delay_setting) < b0)
      wait_upd(n);
      wait_upd(n);
      `CHK("upd_period", 8, n)
      apb(1'b1, 12'h000, 32'h404);
      repeat (3) @(posedge pclk);
      upd_cnt = 0;
      user_clk_tick <= 1'b1;
      @(posedge pclk);
      user_clk_tick <= 1'b0;
      repeat (20) @(posedge pclk);
      `CHK("user_update", 1, upd_cnt)
      // Every shift code, both slow reference modes, short chains.
      for (int e = 0; e < 8; e++) begin
         apb(1'b1, 12'h000, {21'h0, 3'(ct[e]), 2'h0, 2'(md[e]), 4'h0});
         apb(1'b1, 12'h004, {24'h0, {4{2'(sh[e])}}});
         measure(e % 4, n);
         `CHK("shift_delay", exp_delay(sh[e], md[e], ct[e]), n)
      end
      apb(1'b1, 12'h004, 32'h0);
      @(posedge pclk);
      drive <= 4'h0;
      gate_req <= 4'h0;
      repeat (10) begin
         @(posedge pclk);
         #1;
         `CHK("gated_off", 4'h0, strobe_bus)
      end
      // Random strobes and gates; the gate opens at the falling edge.
      repeat (300) begin
         @(posedge pclk);
         gprev = gate_req;
         drive <= 4'($random(seed));
         level <= 4'($random(seed));
         gate_req <= 4'($random(seed));
         phase_up <= 1'($random(seed));
         far_setting <= 7'($random(seed));
         core_setting <= 7'($random(seed));
         #1;
         `CHK("gate_late", strobe_pin & gate_req & gprev, strobe_bus)
         @(negedge pclk);
         #1;
         `CHK("gate_open", strobe_pin & gate_req, strobe_bus)
         `CHK("core_route", strobe_bus, strobe_core)
      end
      end_sim;
   end
endmodule
`default_nettype wire
